// file: src/urxc_pkg.sv
// Shared constants and carrier types for the receive packet check.
// Assumes one system clock; all users refer to names as urxc_pkg::name.
package urxc_pkg;

   // CRC16 as the link transmits it: register preset, polynomial, residual
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_GOOD = 16'h7ff2;   // Inverted residual of a clean packet

   // Trailing CRC bytes that never go to the FIFO
   localparam logic [1:0] CRC_BYTES = 2'h2;

   // Reset values
   localparam logic [15:0] SIZE_RST = 16'h0000;

   // Byte from the receiver front end, same clock as this block
   typedef struct packed
   {
      logic vld;
      logic sop;
      logic eop;
      logic [7:0] data;
   } urxc_rx_t;

   // Byte toward the receive FIFO
   typedef struct packed
   {
      logic vld;
      logic [7:0] data;
   } urxc_wr_t;

   // Packet judging states
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_RECV = 2'b01,
      ST_JUDGE = 2'b10
   } urxc_state_t;

endpackage

// file: src/urxc_crc16.sv
// CRC16 accumulator over received bytes, bits taken least significant first.
// Assumes the caller clears it at packet start and feeds one byte per enable.
`timescale 1ns/10ps
module urxc_crc16
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Byte feed
   input wire logic i_clr,
   input wire logic i_en,
   input wire logic [7:0] i_byte,
   // Result
   output logic [15:0] o_crc
);

   // One byte step of the serial CRC, bit 0 of the byte first on the wire
   function automatic logic [15:0] crc_step(input logic [15:0] c_in, input logic [7:0] d);
      logic [15:0] c;
      logic fb;
      c = c_in;
      fb = 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         fb = c[15] ^ d[i];
         c = {c[14:0], 1'b0};
         if (fb)
         begin
            c = c ^ urxc_pkg::CRC_POLY;
         end
      end
      return c;
   endfunction

   // Clear has priority so a start byte seeds from the preset value
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_crc <= urxc_pkg::CRC_INIT;
      else if (i_clr && i_en)
         o_crc <= crc_step(urxc_pkg::CRC_INIT, i_byte);
      else if (i_clr)
         o_crc <= urxc_pkg::CRC_INIT;
      else if (i_en)
         o_crc <= crc_step(o_crc, i_byte);
   end

endmodule

// file: src/urxc_rx_check.sv
// Receive packet check of a device-mode link controller: CRC, FIFO feed,
// handshake decision, error flag and received size.
// Assumes the front end delivers bytes on i_clk_sys with eop on the last byte.
//
// Function
// - Packet good when CRC residual matches constant
// - Front-end controls arrive together, never staggered
// - Non-isochronous CRC failure drops in-flight FIFO data
// - Non-isochronous CRC failure sends no ACK
// - Isochronous CRC failure raises software-visible error
// - Isochronous CRC failure keeps bytes in FIFO
// - Isochronous packet byte count captured for software
// - All transfer types share one datapath
`timescale 1ns/10ps
module urxc_rx_check
#(
   parameter int SIZE_W = 16
)
(
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // Mode
   input wire logic i_dev_mode,
   input wire logic i_iso,
   // Received bytes
   input wire urxc_pkg::urxc_rx_t i_rx,
   // Software side
   input wire logic i_crc_err_clr,
   output logic o_crc_err,
   output logic [SIZE_W-1:0] o_rx_size,
   output logic o_size_upd,
   // FIFO side
   output urxc_pkg::urxc_wr_t o_fifo_wr,
   output logic o_fifo_commit,
   output logic o_fifo_drop,
   // Handshake request
   output logic o_ack
);

   urxc_pkg::urxc_state_t state_ff;
   urxc_pkg::urxc_state_t nxt_state;
   urxc_pkg::urxc_rx_t rx_ff;
   logic [7:0] hold0_ff;
   logic [7:0] hold1_ff;
   logic [1:0] held_ff;
   logic iso_ff;
   logic [SIZE_W-1:0] cnt_ff;
   logic [15:0] crc;
   logic take;
   logic push;
   logic good;
   logic judge;
   logic start;

   // A taken byte that carries the start mark opens a new packet; the same
   // decode steers the sequencer, the type latch and the byte counter
   function automatic logic opens(input logic taken, input urxc_pkg::urxc_rx_t b);
      return taken && b.sop;
   endfunction

   // Front-end controls are captured in one register stage as a bundle, so
   // valid, start and end are seen in the same cycle with their byte
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         rx_ff <= '0;
      else
         rx_ff <= i_rx;
   end

   assign take = rx_ff.vld && i_dev_mode;
   assign start = opens(take, rx_ff);
   assign judge = (state_ff == urxc_pkg::ST_JUDGE);
   // A byte leaves the hold line only once two newer bytes stand behind it
   assign push = take && (held_ff == urxc_pkg::CRC_BYTES);
   assign good = (~crc == urxc_pkg::CRC_GOOD);

   // One CRC engine for every transfer type
   urxc_crc16 u_crc
   (
      .i_clk_sys(i_clk_sys),
      .i_rst(i_rst),
      .i_clr(rx_ff.sop),
      .i_en(take),
      .i_byte(rx_ff.data),
      .o_crc(crc)
   );

   // Packet sequencing
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         urxc_pkg::ST_IDLE:
         begin
            if (start && rx_ff.eop)
               nxt_state = urxc_pkg::ST_JUDGE;
            else if (start)
               nxt_state = urxc_pkg::ST_RECV;
         end
         urxc_pkg::ST_RECV:
         begin
            if (!i_dev_mode)
               nxt_state = urxc_pkg::ST_IDLE;
            else if (take && rx_ff.eop)
               nxt_state = urxc_pkg::ST_JUDGE;
         end
         urxc_pkg::ST_JUDGE:
         begin
            // A start byte may follow the end byte at once; it must open
            // the next packet here, or that whole packet would be lost
            if (start && rx_ff.eop)
               nxt_state = urxc_pkg::ST_JUDGE;
            else if (start)
               nxt_state = urxc_pkg::ST_RECV;
            else
               nxt_state = urxc_pkg::ST_IDLE;
         end
         default:
            nxt_state = urxc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         state_ff <= urxc_pkg::ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Transfer type is latched at start so a mid-packet change cannot split it
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         iso_ff <= 1'b0;
      else if (start)
         iso_ff <= i_iso;
   end

   // Two-byte hold line keeps the trailing CRC out of the FIFO
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         hold0_ff <= 8'h00;
         hold1_ff <= 8'h00;
         held_ff <= 2'h0;
      end
      else if (take)
      begin
         hold0_ff <= rx_ff.sop ? rx_ff.data : hold1_ff;
         hold1_ff <= rx_ff.data;
         if (rx_ff.sop)
            held_ff <= 2'h1;
         else if (held_ff != urxc_pkg::CRC_BYTES)
            held_ff <= held_ff + 2'h1;
      end
      else if (judge)
      begin
         held_ff <= 2'h0;
      end
   end

   // FIFO write stream, the same path whatever the transfer type
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_fifo_wr <= '0;
      else
      begin
         o_fifo_wr.vld <= push && !rx_ff.sop;
         o_fifo_wr.data <= hold0_ff;
      end
   end

   // Counts exactly the bytes written; the final byte is counted in the
   // same cycle it is pushed, so no off-by-one slips into the size
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         cnt_ff <= '0;
      else if (start)
         cnt_ff <= '0;
      else if (push)
         cnt_ff <= cnt_ff + SIZE_W'(1);
   end

   // Verdict: bad non-isochronous data is flushed and gets no handshake;
   // isochronous data is always kept since the host never resends it
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_fifo_commit <= 1'b0;
         o_fifo_drop <= 1'b0;
         o_ack <= 1'b0;
      end
      else
      begin
         o_fifo_commit <= judge && (iso_ff || good);
         o_fifo_drop <= judge && !iso_ff && !good;
         o_ack <= judge && !iso_ff && good;
      end
   end

   // Received size for software, updated for each isochronous packet
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         o_rx_size <= SIZE_W'(urxc_pkg::SIZE_RST);
         o_size_upd <= 1'b0;
      end
      else
      begin
         o_size_upd <= judge && iso_ff;
         if (judge && iso_ff)
            o_rx_size <= cnt_ff;
      end
   end

   // Sticky error flag; a new error in the clearing cycle wins
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         o_crc_err <= 1'b0;
      else if (judge && iso_ff && !good)
         o_crc_err <= 1'b1;
      else if (i_crc_err_clr)
         o_crc_err <= 1'b0;
   end

endmodule

// file: verif/urxc_rx_chk.sv
// Checker for the receive packet check: verdicts and FIFO feed.
// Assumes it is bound to urxc_rx_check and sees only its ports.
`timescale 1ns/10ps
module urxc_rx_chk
#(
   parameter int SIZE_W = 16
)
(
   // Watched ports
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_dev_mode,
   input wire logic i_iso,
   input wire urxc_pkg::urxc_rx_t i_rx,
   input wire logic i_crc_err_clr,
   input wire logic o_crc_err,
   input wire logic [SIZE_W-1:0] o_rx_size,
   input wire logic o_size_upd,
   input wire urxc_pkg::urxc_wr_t o_fifo_wr,
   input wire logic o_fifo_commit,
   input wire logic o_fifo_drop,
   input wire logic o_ack
);
   logic [SIZE_W-1:0] wcnt_ff;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   // Writes of the packet in flight; the verdict clears it
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || o_fifo_commit || o_fifo_drop)
         wcnt_ff <= '0;
      else if (o_fifo_wr.vld)
         wcnt_ff <= wcnt_ff + SIZE_W'(1);
   end
   // Iso never acks, so an ack excludes a size update
   property p_ack; o_ack |-> o_fifo_commit && !o_size_upd; endproperty
   a_ack: assert property (p_ack) else $error("bad ack");
   property p_pulse; o_ack |=> !o_ack; endproperty
   a_pulse: assert property (p_pulse) else $error("long ack");
   property p_drop; o_fifo_drop |-> !o_fifo_commit && !o_ack && !o_size_upd; endproperty
   a_drop: assert property (p_drop) else $error("bad drop");
   property p_time; o_fifo_commit || o_fifo_drop |-> $past(i_rx.eop, 3) || $past(i_rx.eop, 4); endproperty
   a_time: assert property (p_time) else $error("late verdict");
   property p_err; $rose(o_crc_err) |-> o_size_upd && o_fifo_commit; endproperty
   a_err: assert property (p_err) else $error("stray error");
   property p_keep; o_size_upd |-> o_fifo_commit; endproperty
   a_keep: assert property (p_keep) else $error("iso lost");
   property p_size; $changed(o_rx_size) |-> o_size_upd; endproperty
   a_size: assert property (p_size) else $error("size moved");
   property p_cnt; o_size_upd |-> o_rx_size == wcnt_ff; endproperty
   a_cnt: assert property (p_cnt) else $error("size off");
   cover property (o_ack);
   cover property (o_fifo_drop);
   cover property (o_size_upd && o_crc_err);
endmodule

// file: verif/urxc_host_model.sv
// Host model: sends data packets with CRC16, resends unanswered non-isochronous ones once.
// Assumes i_go is pulsed only while o_busy is low.
`timescale 1ns/10ps
module urxc_host_model
(
   // Clock and request
   input wire logic i_clk_sys,
   input wire logic i_go,
   input wire logic i_bad,
   input wire logic i_iso,
   input wire logic [3:0] i_len,
   // Device side
   input wire logic i_ack,
   output urxc_pkg::urxc_rx_t o_rx,
   output logic o_busy
);
   logic [7:0] pk[$];
   logic acked;
   // Reflected CRC form, low byte first; one bit spoilt on demand
   task automatic send(input logic bad);
      logic [15:0] c;
      logic [7:0] q[$];
      c = 16'hffff;
      q = pk;
      foreach (pk[i])
         for (int b = 0; b < 8; b++)
            c = (c >> 1) ^ ((pk[i][b] ^ c[0]) ? 16'ha001 : 16'h0000);
      q.push_back(~c[7:0] ^ {7'h00, bad});
      q.push_back(~c[15:8]);
      foreach (q[i])
      begin
         @(negedge i_clk_sys);
         o_rx = {1'b1, i == 0, i == q.size() - 1, q[i]};
      end
      @(negedge i_clk_sys);
      o_rx = {3'h0, ~o_rx.data}; // Idle line shows no stale byte
      acked = 1'b0;
      repeat (6) @(posedge i_clk_sys) acked |= i_ack;
   endtask
   // A refused non-isochronous packet goes again, clean; one process owns
   // the outputs so each has a single driver
   initial
   begin
      o_rx = '0;
      o_busy = 1'b0;
      forever
      begin
         @(posedge i_clk_sys);
         if (i_go && !o_busy)
         begin
            o_busy = 1'b1;
            pk.delete();
            repeat (i_len) pk.push_back(8'($urandom));
            send(i_bad);
            if (!i_iso && !acked)
               send(1'b0);
            o_busy = 1'b0;
         end
      end
   end
endmodule

// file: verif/testbench.sv
// Testbench for the receive packet check with host and bench models.
// Assumes the package, host model and checker are compiled first.
`timescale 1ns/10ps
module testbench;
   logic clk = 1'b0, rst = 1'b1, dev = 1'b1, iso = 1'b0, clr = 1'b0, go = 1'b0, bad = 1'b0;
   logic [3:0] len = 4'h1;
   urxc_pkg::urxc_rx_t rx;
   urxc_pkg::urxc_wr_t wr;
   logic err, upd, cmt, drp, ack, busy, pi, pd, ok;
   logic [15:0] size;
   logic [3:0] seen;
   logic [7:0] pk[$], wq[$];
   int cd = 0, nw = 0, n_errors = 0, num_checks = 0;
   // Clock at 250 MHz
   always #2 clk = ~clk;
   urxc_rx_check dut_u
   (
      .i_clk_sys(clk), .i_rst(rst), .i_dev_mode(dev), .i_iso(iso), .i_rx(rx),
      .i_crc_err_clr(clr), .o_crc_err(err), .o_rx_size(size), .o_size_upd(upd),
      .o_fifo_wr(wr), .o_fifo_commit(cmt), .o_fifo_drop(drp), .o_ack(ack)
   );
   urxc_host_model host_u
   (
      .i_clk_sys(clk), .i_go(go), .i_bad(bad), .i_iso(iso), .i_len(len),
      .i_ack(ack), .o_rx(rx), .o_busy(busy)
   );
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      num_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   // One compare per result kind, all counted and reported alike
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
      cmp({8'h00, g}, {8'h00, e});
   endtask
   task automatic cmp_verdict(input logic [3:0] g, input logic [3:0] e);
      cmp({12'h000, g}, {12'h000, e});
   endtask
   task automatic cmp_count(input logic [15:0] g, input logic [15:0] e);
      cmp(g, e);
   endtask
   task automatic cmp_flag(input logic g, input logic e);
      cmp({15'h0000, g}, {15'h0000, e});
   endtask
   // Plain MSB-first form, so it differs from the host's generator
   function automatic logic good(input logic [7:0] q[$]);
      logic [15:0] c = 16'hffff;
      foreach (q[i])
         for (int b = 0; b < 8; b++)
            c = {c[14:0], 1'b0} ^ ((q[i][b] ^ c[15]) ? 16'h8005 : 16'h0000);
      return ~c == 16'h7ff2;
   endfunction
   task automatic complete_run;
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Bench model: follow each packet, judge its verdict window
   always @(posedge clk)
   begin
      if (wr.vld)
      begin
         nw++;
         cmp_byte(wr.data, wq.pop_front());
      end
      if (cd > 0)
      begin
         cd++;
         seen |= {cmt, drp, ack, upd};
      end
      if (cd == 6)
      begin
         cmp_verdict(seen, pd ? {ok | pi, !ok & !pi, ok & !pi, pi} : 4'h0);
         cmp_count(16'(nw), pd ? 16'(pk.size() - 2) : 16'h0000);
         cmp_flag(err, pd & pi & !ok);
         if (pd & pi)
            cmp_count(size, 16'(nw));
         cd = 0;
         nw = 0;
      end
      if (rx.vld && !rst)
      begin
         if (rx.sop)
         begin
            pk.delete();
            pd = dev;
            pi = iso;
         end
         pk.push_back(rx.data);
         if (dev)
            wq.push_back(rx.data);
         if (rx.eop)
         begin
            if (dev)
            begin
               void'(wq.pop_back());
               void'(wq.pop_back());
            end
            ok = good(pk);
            cd = 1;
            seen = 4'h0;
         end
      end
   end
   // All four iso and CRC cases, one packet in ignore mode
   initial
   begin
      void'($urandom(32'h6dad));
      repeat (4) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int t = 0; t < 24; t++)
      begin
         clr = 1'b1;
         go = 1'b1;
         iso = t[0];
         bad = t[1];
         dev = t != 9;
         len = 4'(1 + $urandom % 15);
         @(negedge clk);
         clr = 1'b0;
         go = 1'b0;
         while (busy)
            @(negedge clk);
         repeat (8) @(negedge clk);
      end
      complete_run();
   end
   // Watchdog well past the longest run
   initial
   begin
      #30000;
      n_errors++;
      complete_run();
   end
endmodule
bind urxc_rx_check urxc_rx_chk #(.SIZE_W(SIZE_W)) chk_u (.*);
